// *** dv/adc_control_logic_tb_top.sv ***
// Purpose: Self-checking bench of the converter control block
// Assumes: Zero wait APB slave, model data {channel, 7'h35}
// Notes: Row loop for conversions, hand tests after it
`timescale 1ns/10ps
`include "adcc_regs.svh"
module adc_control_logic_tb_top;
  typedef struct packed {logic [7:0] chen; logic [7:0] ctrl; logic [7:0] div; logic [7:0] hi; logic [7:0] lo;} adcc_row_s;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic pslverr;
  logic irq;
  logic [31:0] prdata;
  logic [7:0] vec;
  logic [9:0] ana_data;
  adcc_pkg::adcc_ana_s ana;
  int mismatches = 0;
  int checks = 0;
  int n;
  int len;
  logic [31:0] q;
  logic e;
  int rises = 0;
  int r0;
  logic cclk_d = 1'b0;
  // Dividers of 5 and up keep the conversion clock and rate legal at 125 MHz
  adcc_row_s rows [4] = '{'{8'h01, 8'h80, 8'h05, 8'h0D, 8'h01}, '{8'h08, 8'hC3, 8'h06, 8'h01, 8'hB5},
    '{8'h80, 8'h87, 8'h1F, 8'hED, 8'h01}, '{8'hFF, 8'hC5, 8'h0A, 8'h02, 8'hB5}};
  always #4 core_clk = ~core_clk;
  // Conversion clock rising edges, counted on the core clock
  always @(posedge core_clk)
  begin
    cclk_d <= ana.conv_clk;
    if (ana.conv_clk && !cclk_d)
    begin
      rises <= rises + 1;
    end
  end
  adcc_ctrl DUT (.CORE_CLK(core_clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .ANA_CTRL(ana),
    .ANA_DATA(ana_data), .ADC_IRQ(irq), .ADC_IRQ_VECTOR(vec));
  adcc_ana_model #(.SETTLE(10)) MODEL (.CORE_CLK(core_clk), .ANA_CTRL(ana), .ANA_DATA(ana_data));
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      mismatches++;
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait on the interrupt or on busy, cycles waited in n
  task automatic wait_for(input bit on_irq, input logic v, input int lim);
    n = 0;
    while (((on_irq ? irq : ana.busy) !== v) && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 'hAB; i <= 'hB2; i++)
    begin
      apb(1'b0, i[9:0], 8'h00);
      chk("reset value", q, 32'h0);
    end
    chk("vector", {24'h0, vec}, 32'h53);
    apb(1'b0, 10'h0B3, 8'h00);
    chk("unmapped error", {31'h0, e}, 32'h1);
    apb(1'b1, `ADCC_IDX_IEN, 8'h01);
    foreach (rows[i])
    begin
      apb(1'b1, `ADCC_IDX_CHEN, rows[i].chen);
      apb(1'b1, `ADCC_IDX_CDIV, rows[i].div);
      apb(1'b1, `ADCC_IDX_CTRL, rows[i].ctrl);
      wait_for(1'b0, 1'b1, 10);
      r0 = rises;
      wait_for(1'b1, 1'b1, 900);
      len = 26 * (rows[i].div + 1);
      chk("conv clock rises", rises - r0, `ADCC_CONV_CLKS);
      chk("conversion length", {31'h0, n >= len && n <= len + 3}, 32'h1);
      chk("channel routed", {29'h0, ana.sel}, {29'h0, rows[i].ctrl[2:0]});
      chk("channel enables", {24'h0, ana.chan_en}, {24'h0, rows[i].chen});
      chk("reference enable", {31'h0, ana.ref_en}, {31'h0, rows[i].chen[0]});
      apb(1'b1, `ADCC_IDX_ICLR, 8'h01);
      wait_for(1'b1, 1'b0, 5);
      wait_for(1'b1, 1'b1, 900);
      chk("busy held", {31'h0, ana.busy}, 32'h1);
      // Clear lands on the very edge that ends the next conversion
      repeat (len - 4) @(posedge core_clk);
      apb(1'b1, `ADCC_IDX_ICLR, 8'h01);
      apb(1'b0, `ADCC_IDX_ISTS, 8'h00);
      chk("set beats clear", q, 32'h1);
      apb(1'b1, `ADCC_IDX_CTRL, rows[i].ctrl & 8'h7F);
      wait_for(1'b0, 1'b0, 900);
      apb(1'b0, `ADCC_IDX_RESH, 8'h00);
      chk("result high", q, {24'h0, rows[i].hi});
      apb(1'b0, `ADCC_IDX_RESL, 8'h00);
      chk("result low", q, {24'h0, rows[i].lo});
      apb(1'b1, `ADCC_IDX_ICLR, 8'h01);
    end
    // Result registers ignore writes
    apb(1'b1, `ADCC_IDX_RESH, 8'hFF);
    apb(1'b0, `ADCC_IDX_RESH, 8'h00);
    chk("result read only", q, {24'h0, rows[3].hi});
    // Disabled channel must not convert
    apb(1'b1, `ADCC_IDX_IEN, 8'h00);
    apb(1'b1, `ADCC_IDX_CHEN, 8'hFB);
    apb(1'b1, `ADCC_IDX_CTRL, 8'h82);
    repeat (40) @(posedge core_clk);
    chk("disabled channel idle", {31'h0, ana.busy}, 32'h0);
    apb(1'b1, `ADCC_IDX_CHEN, 8'h04);
    wait_for(1'b0, 1'b1, 10);
    apb(1'b1, `ADCC_IDX_CTRL, 8'h02);
    wait_for(1'b0, 1'b0, 900);
    repeat (3) @(posedge core_clk);
    chk("masked interrupt", {31'h0, irq}, 32'h0);
    apb(1'b0, `ADCC_IDX_ISTS, 8'h00);
    chk("done status", q, 32'h1);
    apb(1'b1, `ADCC_IDX_IEN, 8'h01);
    wait_for(1'b1, 1'b1, 5);
    apb(1'b1, `ADCC_IDX_ICLR, 8'h01);
    wait_for(1'b1, 1'b0, 5);
    // Reset in the middle of a conversion
    apb(1'b1, `ADCC_IDX_CTRL, 8'h82);
    wait_for(1'b0, 1'b1, 10);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk("busy after reset", {31'h0, ana.busy}, 32'h0);
    chk("conv clock after reset", {31'h0, ana.conv_clk}, 32'h0);
    chk("irq after reset", {31'h0, irq}, 32'h0);
    apb(1'b0, `ADCC_IDX_RESH, 8'h00);
    chk("result high after reset", q, 32'h0);
    apb(1'b0, `ADCC_IDX_RESL, 8'h00);
    chk("result low after reset", q, 32'h0);
    apb(1'b0, `ADCC_IDX_CTRL, 8'h00);
    chk("control after reset", q, 32'h0);
    apb(1'b0, `ADCC_IDX_CHEN, 8'h00);
    chk("enables after reset", q, 32'h0);
    repeat (10) @(posedge core_clk);
    chk("idle after reset", {31'h0, ana.busy}, 32'h0);
    report_and_stop();
  end
endmodule // adc_control_logic_tb_top

// *** dv/adcc_ana_model.sv ***
// Purpose: Behavioural analog converter core facing the control block
// Assumes: Result depends on the routed channel only
// Notes: Data settles SETTLE cycles into a conversion, inverse shown otherwise
`timescale 1ns/10ps
module adcc_ana_model
#(
  parameter int SETTLE = 4
)
(
  // Clock
  input wire logic CORE_CLK,
  // Control side
  input wire adcc_pkg::adcc_ana_s ANA_CTRL,
  output logic [9:0] ANA_DATA
);
  logic [9:0] last_r = 10'h000;
  int cnt = 0;
  // Slow settling, so a capture too early sees wrong data
  always @(posedge CORE_CLK)
  begin
    cnt <= ANA_CTRL.busy ? cnt + 1 : 0;
    if (ANA_CTRL.busy)
    begin
      last_r <= {ANA_CTRL.sel, 7'h35};
    end
  end
  assign ANA_DATA = (ANA_CTRL.busy && cnt >= SETTLE) ? {ANA_CTRL.sel, 7'h35} : ~last_r;
endmodule // adcc_ana_model

// *** hdl/adcc_ctrl.sv ***
// Purpose: Register file, conversion sequencer and result formatting of the converter
// Assumes: APB slave, zero wait states; analog data settles before conversion end
// Notes: Analog result crosses in through two flip-flops
//
// How it works
// RULE_01 - A 10-bit result is kept and all ten bits are readable through the two result registers.
// RULE_02 - Each of the eight channel enable bits, when 1, enables its input channel 7 down to 0.
// RULE_03 - Channel 0 is the internal voltage reference, enabled by its own enable bit.
// RULE_04 - While the start bit is set, conversions run back to back.
// RULE_05 - With alignment 0, high register holds bits 9..2 and low register bits 1..0 hold bits 1..0.
// RULE_06 - With alignment 1, high register bits 1..0 hold bits 9..8 and low register holds bits 7..0.
// RULE_07 - The 3-bit channel select routes channel n, its binary value, to the converter.
// RULE_08 - Conversion clock is the core clock divided by two times divider plus one.
// RULE_09 - A conversion takes 13 conversion clocks, 26 to 832 core cycles.
// RULE_10 - Software keeps the conversion clock at or below 12.5 MHz.
// RULE_11 - Software keeps the conversion rate at or below 961 kHz.
// RULE_12 - The interrupt is serviced through vector address 53H.
// RULE_13 - An interrupt request is raised each time a result is written.
// RULE_14 - Unused result bit positions read zero and both result registers reset to zero.
`timescale 1ns/10ps
`include "adcc_regs.svh"
module adcc_ctrl
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // Analog core
  output adcc_pkg::adcc_ana_s ANA_CTRL,
  input wire logic [9:0] ANA_DATA,
  // Interrupt
  output logic ADC_IRQ,
  output logic [7:0] ADC_IRQ_VECTOR
);

  logic [7:0] chen_r;
  logic [7:0] chen_nxt;
  logic start_r;
  logic start_nxt;
  logic adj_r;
  logic adj_nxt;
  logic [2:0] ch_r;
  logic [2:0] ch_nxt;
  logic [4:0] div_r;
  logic [4:0] div_nxt;
  logic [9:0] res_r;
  logic [9:0] res_nxt;
  logic sts_r;
  logic sts_nxt;
  logic ien_r;
  logic ien_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  adcc_pkg::adcc_state_e state_r;
  adcc_pkg::adcc_state_e state_nxt;
  logic [4:0] hc_r;
  logic [4:0] hc_nxt;
  logic [4:0] half_r;
  logic [4:0] half_nxt;
  logic cclk_r;
  logic cclk_nxt;
  logic [4:0] divq_r;
  logic [4:0] divq_nxt;
  logic [2:0] sel_r;
  logic [2:0] sel_nxt;
  logic [9:0] dsync1_r;
  logic [9:0] dsync2_r;
  logic [9:0] idx;
  logic wr;
  logic rd_setup;
  logic hit;
  logic go;
  logic done;
  logic [7:0] rd_byte;

  assign idx = PADDR[11:2];
  assign wr = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
  assign go = start_r & chen_r[ch_r]; // see RULE_02
  assign done = (state_r == adcc_pkg::ST_CONV) && (hc_r == divq_r)
    && (half_r == 5'(`ADCC_HALVES - 1)); // see RULE_09

  // Address decode
  always_comb
  begin
    hit = 1'b1;
    rd_byte = `ADCC_RST_BYTE;
    case (idx)
      `ADCC_IDX_CHEN: rd_byte = chen_r;
      `ADCC_IDX_CTRL: rd_byte = {start_r, adj_r, 3'h0, ch_r};
      `ADCC_IDX_RESH: rd_byte = adj_r ? {6'h00, res_r[9:8]} : res_r[9:2]; // see RULE_05 see RULE_06
      `ADCC_IDX_RESL: rd_byte = adj_r ? res_r[7:0] : {6'h00, res_r[1:0]}; // see RULE_14 see RULE_01
      `ADCC_IDX_CDIV: rd_byte = {3'h0, div_r};
      `ADCC_IDX_ISTS: rd_byte = {7'h00, sts_r};
      `ADCC_IDX_ICLR: rd_byte = `ADCC_RST_BYTE;
      `ADCC_IDX_IEN: rd_byte = {7'h00, ien_r};
      default: hit = 1'b0;
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & ~hit;
  assign PRDATA = prdata_r;

  // Register file next values
  always_comb
  begin
    chen_nxt = chen_r;
    start_nxt = start_r;
    adj_nxt = adj_r;
    ch_nxt = ch_r;
    div_nxt = div_r;
    ien_nxt = ien_r;
    sts_nxt = sts_r;
    if (wr)
    begin
      case (idx)
        `ADCC_IDX_CHEN: chen_nxt = PWDATA[7:0]; // see RULE_02
        `ADCC_IDX_CTRL:
        begin
          start_nxt = PWDATA[`ADCC_CTRL_START]; // see RULE_04
          adj_nxt = PWDATA[`ADCC_CTRL_ADJ];
          ch_nxt = PWDATA[`ADCC_CTRL_CH_HI:0];
        end
        `ADCC_IDX_CDIV: div_nxt = PWDATA[`ADCC_CDIV_HI:0];
        `ADCC_IDX_ICLR: sts_nxt = sts_r & ~PWDATA[`ADCC_IRQ_DONE];
        `ADCC_IDX_IEN: ien_nxt = PWDATA[`ADCC_IRQ_DONE];
        default: ;
      endcase
    end
    // Set wins over a clear in the same cycle
    if (done)
    begin
      sts_nxt = 1'b1; // see RULE_13
    end
    res_nxt = done ? dsync2_r : res_r; // see RULE_01
    prdata_nxt = rd_setup ? {24'h000000, rd_byte} : prdata_r;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      chen_r <= `ADCC_RST_BYTE;
      start_r <= 1'b0;
      adj_r <= 1'b0;
      ch_r <= 3'h0;
      div_r <= 5'h00;
      res_r <= `ADCC_RST_RES; // see RULE_14
      sts_r <= 1'b0;
      ien_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      chen_r <= chen_nxt;
      start_r <= start_nxt;
      adj_r <= adj_nxt;
      ch_r <= ch_nxt;
      div_r <= div_nxt;
      res_r <= res_nxt;
      sts_r <= sts_nxt;
      ien_r <= ien_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Sequencer: divider and channel are latched per conversion so a write mid-way cannot tear it
  always_comb
  begin
    state_nxt = state_r;
    hc_nxt = hc_r;
    half_nxt = half_r;
    cclk_nxt = cclk_r;
    divq_nxt = divq_r;
    sel_nxt = sel_r;
    case (state_r)
      adcc_pkg::ST_IDLE:
      begin
        if (go)
        begin
          state_nxt = adcc_pkg::ST_CONV;
          hc_nxt = 5'h00;
          half_nxt = 5'h00;
          cclk_nxt = 1'b0;
          divq_nxt = div_r;
          sel_nxt = ch_r; // see RULE_07
        end
      end
      adcc_pkg::ST_CONV:
      begin
        if (hc_r == divq_r)
        begin
          hc_nxt = 5'h00;
          cclk_nxt = ~cclk_r; // see RULE_08
          half_nxt = half_r + 5'h01;
          if (done)
          begin
            half_nxt = 5'h00;
            cclk_nxt = 1'b0;
            if (go)
            begin
              divq_nxt = div_r; // see RULE_04
              sel_nxt = ch_r;
            end
            else
            begin
              state_nxt = adcc_pkg::ST_IDLE;
            end
          end
        end
        else
        begin
          hc_nxt = hc_r + 5'h01;
        end
      end
      default: state_nxt = adcc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      state_r <= adcc_pkg::ST_IDLE;
      hc_r <= 5'h00;
      half_r <= 5'h00;
      cclk_r <= 1'b0;
      divq_r <= 5'h00;
      sel_r <= 3'h0;
      dsync1_r <= `ADCC_RST_RES;
      dsync2_r <= `ADCC_RST_RES;
    end
    else
    begin
      state_r <= state_nxt;
      hc_r <= hc_nxt;
      half_r <= half_nxt;
      cclk_r <= cclk_nxt;
      divq_r <= divq_nxt;
      sel_r <= sel_nxt;
      dsync1_r <= ANA_DATA;
      dsync2_r <= dsync1_r;
    end
  end

  // Analog side and interrupt
  // One driver for the whole struct
  always_comb
  begin
    ANA_CTRL.chan_en = chen_r; // see RULE_02
    ANA_CTRL.ref_en = chen_r[0]; // see RULE_03
    ANA_CTRL.sel = sel_r;
    ANA_CTRL.conv_clk = cclk_r;
    ANA_CTRL.busy = (state_r == adcc_pkg::ST_CONV);
  end
  assign ADC_IRQ = sts_r & ien_r; // see RULE_13
  assign ADC_IRQ_VECTOR = `ADCC_VECTOR; // see RULE_12

  // Checks
  logic [9:0] len_r;
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N || done || state_r != adcc_pkg::ST_CONV)
    begin
      len_r <= 10'h000;
    end
    else
    begin
      len_r <= len_r + 10'h001;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  conv_length_a: assert property (done |-> len_r == // see RULE_09
    10'(`ADCC_HALVES) * (10'(divq_r) + 10'h001) - 10'h001)
    else $error("conversion length wrong");
  res_capture_a: assert property (done |=> res_r == $past(dsync2_r) && sts_r) // see RULE_13
    else $error("result not captured");
  set_wins_a: assert property (done && wr && idx == `ADCC_IDX_ICLR |=> sts_r) // see RULE_13
    else $error("done flag lost to clear");
  continuous_a: assert property (done && go |=> ANA_CTRL.busy && half_r == 5'h00) // see RULE_04
    else $error("no back to back conversion");
  chan_gate_a: assert property (state_r == adcc_pkg::ST_IDLE && !go |=> !ANA_CTRL.busy) // see RULE_02
    else $error("disabled channel converted");
  chan_sel_a: assert property ($rose(ANA_CTRL.busy) |-> ANA_CTRL.sel == $past(ch_r)) // see RULE_07
    else $error("wrong channel routed");
  clk_toggle_a: assert property (ANA_CTRL.busy && hc_r != divq_r |=> $stable(cclk_r)) // see RULE_08
    else $error("conversion clock toggled early");
  high_fmt_a: assert property (PREADY && !PWRITE && idx == `ADCC_IDX_RESH && !$past(adj_r) // see RULE_05
    |-> PRDATA[7:0] == $past(res_r[9:2]))
    else $error("high byte left format wrong");
  low_fmt_a: assert property (PREADY && !PWRITE && idx == `ADCC_IDX_RESL && $past(adj_r) // see RULE_06
    |-> PRDATA[7:0] == $past(res_r[7:0]))
    else $error("low byte right format wrong");
  zero_fill_a: assert property (PREADY && !PWRITE && idx == `ADCC_IDX_RESL && !$past(adj_r) // see RULE_14
    |-> PRDATA[31:2] == 30'h00000000)
    else $error("unused result bits not zero");

  conv_done_c: cover property (done);
  back_to_back_c: cover property (done ##[1:900] done);
  irq_c: cover property (ADC_IRQ);
  right_read_c: cover property (PREADY && !PWRITE && idx == `ADCC_IDX_RESH && adj_r);

endmodule // adcc_ctrl

// *** inc/adcc_pkg.sv ***
// Purpose: Types of the converter control block
// Assumes: Nothing
// Notes: Analog side controls travel as one struct
package adcc_pkg;
  typedef enum logic {ST_IDLE, ST_CONV} adcc_state_e;
  typedef struct packed {
    logic [7:0] chan_en;
    logic ref_en;
    logic [2:0] sel;
    logic conv_clk;
    logic busy;
  } adcc_ana_s;
endpackage

// *** inc/adcc_regs.svh ***
// Purpose: Offsets, field positions and counts of the converter control block
// Assumes: Register index times four is the APB byte address
// Notes: Reserved bits read as zero
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH
// Register indices (byte address = 4 * index)
`define ADCC_IDX_CHEN 10'h0AB
`define ADCC_IDX_CTRL 10'h0AC
`define ADCC_IDX_RESH 10'h0AD
`define ADCC_IDX_RESL 10'h0AE
`define ADCC_IDX_CDIV 10'h0AF
`define ADCC_IDX_ISTS 10'h0B0
`define ADCC_IDX_ICLR 10'h0B1
`define ADCC_IDX_IEN 10'h0B2
// Field positions
`define ADCC_CTRL_START 7
`define ADCC_CTRL_ADJ 6
`define ADCC_CTRL_CH_HI 2
`define ADCC_CDIV_HI 4
`define ADCC_IRQ_DONE 0
// Reset values
`define ADCC_RST_BYTE 8'h00
`define ADCC_RST_RES 10'h000
// Timing
`define ADCC_CONV_CLKS 13
`define ADCC_HALVES (2 * `ADCC_CONV_CLKS)
// Interrupt vector of the converter
`define ADCC_VECTOR 8'h53
`endif
